/* design/freq_ref_defs.vh */
// register offsets, field layout and timing constants for the frequency reference selector
`ifndef FREQ_REF_DEFS_VH
`define FREQ_REF_DEFS_VH

// register word offsets (byte addresses)
`define OFS_MAIN_SRC 8'h00
`define OFS_AUX_SRC 8'h04
`define OFS_AUX_REF 8'h08
`define OFS_AUX_PCT 8'h0c
`define OFS_MODE 8'h10
`define OFS_PRESET 8'h14
`define OFS_MAXF 8'h18
`define OFS_OFFSET 8'h1c
`define OFS_PROTO 8'h20
`define OFS_COMM 8'h24
`define OFS_TARGET 8'h28
`define OFS_STATUS 8'h2c
`define OFS_MAIN_VAL 8'h30
`define OFS_AUX_VAL 8'h34
`define OFS_MREF_BASE 8'h40
`define MREF_IDX_HI 4'h7
`define MREF_IDX_LO 2'h1

// reset values
`define RST_ZERO 16'h0000
`define RST_PRESET 16'h1388
`define RST_MAXF 16'h1388

// channel codes shared by main and auxiliary selectors
`define CH_DIG_VOLATILE 4'h0
`define CH_DIG_RETAIN 4'h1
`define CH_ANA_V 4'h2
`define CH_ANA_DUAL 4'h3
`define CH_ANA_BIP 4'h4
`define CH_PULSE 4'h5
`define CH_MREF 4'h6
`define CH_PLC 4'h7
`define CH_PID 4'h8
`define CH_COMM 4'h9

// units digit of the mode
`define UNIT_MAIN 4'h0
`define UNIT_COMB 4'h1
`define UNIT_SW_XY 4'h2
`define UNIT_SW_XC 4'h3
`define UNIT_SW_YC 4'h4

// tens digit of the mode
`define OP_SUM 4'h0
`define OP_DIFF 4'h1
`define OP_MAX 4'h2
`define OP_MIN 4'h3

// scaling: 10000 counts are 100 percent of an input, range percent up to 150
`define FULL_SCALE 32'sh0000_2710
`define PCT_DIV 32'sh0000_0064
`define AUX_PCT_MAX 16'h0096

// update interval: time in ns and clock rate in kHz
`define UPDATE_NS 1000
`define CLK_KHZ 25000
`define UPDATE_CYC ((`UPDATE_NS * `CLK_KHZ) / 1000000)

`endif

/* design/freq_ref_select.v */
// frequency reference selector: main/aux channel pick, combination and switchover
// Functional notes
// - four speed terminals pick one of sixteen preset entries as reference.
// - a preset entry is a percentage of maximum frequency.
// - only one host protocol is enabled at any time.
// - auxiliary selector uses the same ten channel codes zero to nine.
// - digital aux in combination ignores preset; up/down act on value directly.
// - full-scale analog or pulse aux maps to the auxiliary range; the code does so only in combination, max frequency under units digit two.
// - range reference zero scales to max frequency, one to main frequency.
// - auxiliary range percent accepts zero to 150 and scales the aux.
// - main-relative aux span follows every change of main frequency.
// - units digit zero gives the main value as target.
// - units digit one gives the combination result chosen by tens digit.
// - units digit two gives main, or aux while switchover input active.
// - units digit three gives main, or combination while switchover active.
// - units digit four gives aux, or combination while switchover active.
// - tens digit zero sums main and auxiliary.
// - tens digit one subtracts auxiliary from main.
// - tens digit two takes the value of larger magnitude.
// - offset frequency is added to every combination result.
// - tens digit three takes the value of smaller magnitude.
// - main selector chooses among ten channels with the same codes.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "freq_ref_defs.vh"

module freq_ref_select #(
	parameter UPDATE_DIV = `UPDATE_CYC,
	parameter [15:0] DIG_STEP = 16'h0001
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// wishbone classic slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// reference inputs, signed, 10000 is full scale
	input wire [15:0] analog_voltage_input,
	input wire [15:0] analog_dual_input,
	input wire [15:0] analog_bipolar_input,
	input wire [15:0] pulse_input_terminal,
	input wire [15:0] plc_reference,
	input wire [15:0] pid_reference,
	// digital terminals
	input wire [3:0] speed_select,
	input wire freq_switch,
	input wire up_pulse,
	input wire down_pulse,
	// results
	output reg [15:0] target_freq_q,
	output reg [3:0] protocol_enable_q,
	output reg target_update_q
);

	// configuration registers
	reg [3:0] main_source_select_q;
	reg [3:0] aux_source_select_q;
	reg aux_range_reference_q;
	reg [15:0] aux_range_percent_q;
	reg [15:0] freq_source_mode_q;
	reg [15:0] preset_frequency_q;
	reg [15:0] max_frequency_q;
	reg [15:0] combination_offset_q;
	reg [1:0] serial_protocol_select_q;
	reg [15:0] comm_setting_q;
	reg [15:0] mref_q [0:15];

	// digital setting values and update timing
	reg [15:0] main_dig_q;
	reg [15:0] aux_dig_q;
	reg dig_loaded_q;
	reg [15:0] div_q;
	reg tick_q;
	reg [15:0] main_val_q;
	reg [15:0] aux_val_q;

	// bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;
	wire mref_hit = (wb_adr_i[7:6] == `MREF_IDX_LO);
	wire [3:0] mref_idx = wb_adr_i[5:2];

	// mode digits
	wire [15:0] unit_w = freq_source_mode_q % 16'h000a;
	wire [15:0] tens_w = (freq_source_mode_q / 16'h000a) % 16'h000a;
	wire [3:0] unit_d = unit_w[3:0];
	wire [3:0] tens_d = tens_w[3:0];
	wire comb_used = (unit_d == `UNIT_COMB) | (unit_d == `UNIT_SW_XC) | (unit_d == `UNIT_SW_YC);

	// byte-lane merge for 16-bit registers
	function [15:0] lane;
		input [15:0] old;
		input [31:0] d;
		input [3:0] sel;
		begin
			lane = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	// signed percent of a base, full scale 10000
	function signed [31:0] scl;
		input signed [31:0] pct;
		input signed [31:0] base;
		begin
			scl = (pct * base) / `FULL_SCALE;
		end
	endfunction

	// magnitude for max/min selection
	function [31:0] mag;
		input signed [31:0] v;
		begin
			mag = v[31] ? -v : v;
		end
	endfunction

	// clamp into plus or minus maximum frequency
	function [15:0] clampf;
		input signed [31:0] v;
		input [15:0] mx;
		reg signed [31:0] lim;
		begin
			lim = $signed({16'h0, mx});
			if (v > lim) begin
				clampf = mx;
			end else if (v < -lim) begin
				clampf = -mx;
			end else begin
				clampf = v[15:0];
			end
		end
	endfunction

	// percent input of a channel, zero for channels given as frequency
	function signed [31:0] ch_pct;
		input [3:0] code;
		input [15:0] av;
		input [15:0] ad;
		input [15:0] ab;
		input [15:0] pu;
		input [15:0] mr;
		input [15:0] pl;
		input [15:0] pd;
		begin
			case (code)
				`CH_ANA_V: ch_pct = $signed({{16{av[15]}}, av});
				`CH_ANA_DUAL: ch_pct = $signed({{16{ad[15]}}, ad});
				`CH_ANA_BIP: ch_pct = $signed({{16{ab[15]}}, ab});
				`CH_PULSE: ch_pct = $signed({{16{pu[15]}}, pu});
				`CH_MREF: ch_pct = $signed({{16{mr[15]}}, mr});
				`CH_PLC: ch_pct = $signed({{16{pl[15]}}, pl});
				`CH_PID: ch_pct = $signed({{16{pd[15]}}, pd});
				default: ch_pct = 32'sd0;
			endcase
		end
	endfunction

	// current preset entry from the speed terminals
	wire [15:0] mref_sel = mref_q[speed_select];
	wire signed [31:0] maxf_s = $signed({16'h0, max_frequency_q});

	// main value X
	reg signed [31:0] x_s;
	always @* begin
		case (main_source_select_q)
			`CH_DIG_VOLATILE, `CH_DIG_RETAIN: x_s = $signed({{16{main_dig_q[15]}}, main_dig_q});
			`CH_COMM: x_s = $signed({{16{comm_setting_q[15]}}, comm_setting_q});
			default: x_s = scl(ch_pct(main_source_select_q, analog_voltage_input, analog_dual_input,
				analog_bipolar_input, pulse_input_terminal, mref_sel, plc_reference, pid_reference), maxf_s);
		endcase
	end

	// auxiliary span and value Y
	wire [15:0] pct_lim = (aux_range_percent_q > `AUX_PCT_MAX) ? `AUX_PCT_MAX : aux_range_percent_q;
	wire signed [31:0] span_s = aux_range_reference_q ? $signed(mag(x_s)) : maxf_s;
	wire signed [31:0] rng_s = (span_s * $signed({16'h0, pct_lim})) / `PCT_DIV;
	reg signed [31:0] y_s;
	always @* begin
		case (aux_source_select_q)
			`CH_DIG_VOLATILE, `CH_DIG_RETAIN: begin
				// in combination the preset is bypassed: only the up/down trim counts
				y_s = comb_used ? $signed({{16{aux_dig_q[15]}}, aux_dig_q}) :
					$signed({{16{main_dig_q[15]}}, main_dig_q});
			end
			`CH_COMM: y_s = $signed({{16{comm_setting_q[15]}}, comm_setting_q});
			default: begin
				if (comb_used) begin
					y_s = scl(ch_pct(aux_source_select_q, analog_voltage_input, analog_dual_input,
						analog_bipolar_input, pulse_input_terminal, mref_sel, plc_reference, pid_reference),
						rng_s);
				end else begin
					y_s = scl(ch_pct(aux_source_select_q, analog_voltage_input, analog_dual_input,
						analog_bipolar_input, pulse_input_terminal, mref_sel, plc_reference, pid_reference),
						maxf_s);
				end
			end
		endcase
	end

	// combination result with offset
	reg signed [31:0] c_s;
	always @* begin
		case (tens_d)
			`OP_SUM: c_s = x_s + y_s;
			`OP_DIFF: c_s = x_s - y_s;
			`OP_MAX: c_s = (mag(x_s) >= mag(y_s)) ? x_s : y_s;
			`OP_MIN: c_s = (mag(x_s) <= mag(y_s)) ? x_s : y_s;
			default: c_s = x_s + y_s;
		endcase
		c_s = c_s + $signed({{16{combination_offset_q[15]}}, combination_offset_q});
	end

	// target selection by units digit and switchover terminal
	reg signed [31:0] t_s;
	always @* begin
		case (unit_d)
			`UNIT_MAIN: t_s = x_s;
			`UNIT_COMB: t_s = c_s;
			`UNIT_SW_XY: t_s = freq_switch ? y_s : x_s;
			`UNIT_SW_XC: t_s = freq_switch ? c_s : x_s;
			`UNIT_SW_YC: t_s = freq_switch ? c_s : y_s;
			default: t_s = x_s;
		endcase
	end

	// update divider: target, main and aux values move together on one tick
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if ({16'h0000, div_q} >= UPDATE_DIV - 1) begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// registered target; a single sample avoids mixing old and new settings
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			target_freq_q <= 16'h0000;
			main_val_q <= 16'h0000;
			aux_val_q <= 16'h0000;
			target_update_q <= 1'b0;
		end else begin
			target_update_q <= tick_q;
			if (tick_q) begin
				target_freq_q <= clampf(t_s, max_frequency_q);
				main_val_q <= clampf(x_s, max_frequency_q);
				aux_val_q <= clampf(y_s, max_frequency_q);
			end
		end
	end

	// protocol enable: one-hot, so two protocols can never run together
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			protocol_enable_q <= 4'h0;
		end else begin
			protocol_enable_q <= 4'h1 << serial_protocol_select_q;
		end
	end

	// main digital setting: load preset once after reset and on preset write; aux trim starts at zero
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			main_dig_q <= `RST_ZERO;
			aux_dig_q <= `RST_ZERO;
			dig_loaded_q <= 1'b0;
		end else if (!dig_loaded_q || (wb_wr && wb_adr_i == `OFS_PRESET)) begin
			main_dig_q <= dig_loaded_q ? lane(preset_frequency_q, wb_dat_i, wb_sel_i) : preset_frequency_q;
			dig_loaded_q <= 1'b1;
		end else if (up_pulse && !down_pulse) begin
			if (comb_used && aux_source_select_q <= `CH_DIG_RETAIN) begin
				aux_dig_q <= aux_dig_q + DIG_STEP;
			end else begin
				main_dig_q <= main_dig_q + DIG_STEP;
			end
		end else if (down_pulse && !up_pulse) begin
			if (comb_used && aux_source_select_q <= `CH_DIG_RETAIN) begin
				aux_dig_q <= aux_dig_q - DIG_STEP;
			end else begin
				main_dig_q <= main_dig_q - DIG_STEP;
			end
		end
	end

	// register writes
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			main_source_select_q <= 4'h0;
			aux_source_select_q <= 4'h0;
			aux_range_reference_q <= 1'b0;
			aux_range_percent_q <= `RST_ZERO;
			freq_source_mode_q <= `RST_ZERO;
			preset_frequency_q <= `RST_PRESET;
			max_frequency_q <= `RST_MAXF;
			combination_offset_q <= `RST_ZERO;
			serial_protocol_select_q <= 2'h0;
			comm_setting_q <= `RST_ZERO;
		end else if (wb_wr && wb_sel_i[0]) begin
			case (wb_adr_i)
				// codes above nine are refused so the selectors stay in range
				`OFS_MAIN_SRC: if (wb_dat_i[3:0] <= `CH_COMM) main_source_select_q <= wb_dat_i[3:0];
				`OFS_AUX_SRC: if (wb_dat_i[3:0] <= `CH_COMM) aux_source_select_q <= wb_dat_i[3:0];
				`OFS_AUX_REF: aux_range_reference_q <= wb_dat_i[0];
				`OFS_AUX_PCT: aux_range_percent_q <= lane(aux_range_percent_q, wb_dat_i, wb_sel_i);
				`OFS_MODE: freq_source_mode_q <= lane(freq_source_mode_q, wb_dat_i, wb_sel_i);
				`OFS_PRESET: preset_frequency_q <= lane(preset_frequency_q, wb_dat_i, wb_sel_i);
				`OFS_MAXF: max_frequency_q <= lane(max_frequency_q, wb_dat_i, wb_sel_i);
				`OFS_OFFSET: combination_offset_q <= lane(combination_offset_q, wb_dat_i, wb_sel_i);
				`OFS_PROTO: serial_protocol_select_q <= wb_dat_i[1:0];
				`OFS_COMM: comm_setting_q <= lane(comm_setting_q, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end else if (wb_wr && wb_sel_i[1]) begin
			// upper byte only
			case (wb_adr_i)
				`OFS_AUX_PCT: aux_range_percent_q <= lane(aux_range_percent_q, wb_dat_i, wb_sel_i);
				`OFS_MODE: freq_source_mode_q <= lane(freq_source_mode_q, wb_dat_i, wb_sel_i);
				`OFS_PRESET: preset_frequency_q <= lane(preset_frequency_q, wb_dat_i, wb_sel_i);
				`OFS_MAXF: max_frequency_q <= lane(max_frequency_q, wb_dat_i, wb_sel_i);
				`OFS_OFFSET: combination_offset_q <= lane(combination_offset_q, wb_dat_i, wb_sel_i);
				`OFS_COMM: comm_setting_q <= lane(comm_setting_q, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// preset table: one entry per terminal combination, reset to zero
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_mref
			always @(posedge ref_clk) begin
				if (!rst_n) begin
					mref_q[gi] <= `RST_ZERO;
				end else if (wb_wr && mref_hit && {28'h0000000, mref_idx} == gi) begin
					mref_q[gi] <= lane(mref_q[gi], wb_dat_i, wb_sel_i);
				end
			end
		end
	endgenerate

	// flags: conflicting channels are reported, not fixed, since software owns them
	wire src_conflict = (main_source_select_q == aux_source_select_q);

	// read mux and single-cycle ack
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				if (mref_hit) begin
					wb_dat_o <= {16'h0000, mref_q[mref_idx]};
				end else begin
					case (wb_adr_i)
						`OFS_MAIN_SRC: wb_dat_o <= {28'h0, main_source_select_q};
						`OFS_AUX_SRC: wb_dat_o <= {28'h0, aux_source_select_q};
						`OFS_AUX_REF: wb_dat_o <= {31'h0, aux_range_reference_q};
						`OFS_AUX_PCT: wb_dat_o <= {16'h0000, aux_range_percent_q};
						`OFS_MODE: wb_dat_o <= {16'h0000, freq_source_mode_q};
						`OFS_PRESET: wb_dat_o <= {16'h0000, preset_frequency_q};
						`OFS_MAXF: wb_dat_o <= {16'h0000, max_frequency_q};
						`OFS_OFFSET: wb_dat_o <= {16'h0000, combination_offset_q};
						`OFS_PROTO: wb_dat_o <= {30'h0, serial_protocol_select_q};
						`OFS_COMM: wb_dat_o <= {16'h0000, comm_setting_q};
						`OFS_TARGET: wb_dat_o <= {16'h0000, target_freq_q};
						`OFS_STATUS: wb_dat_o <= {24'h0, tens_d, freq_switch, comb_used, dig_loaded_q, src_conflict};
						`OFS_MAIN_VAL: wb_dat_o <= {16'h0000, main_val_q};
						`OFS_AUX_VAL: wb_dat_o <= {16'h0000, aux_val_q};
						default: wb_dat_o <= 32'h0000_0000;
					endcase
				end
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

endmodule // freq_ref_select

/* verif/freq_ref_select_asserts.sv */
// port checker for the frequency reference selector
`timescale 1ns/1ps
module freq_ref_select_asserts #(
	parameter UPDATE_DIV = 25
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// results
	input wire [15:0] target_freq_q,
	input wire [3:0] protocol_enable_q,
	input wire target_update_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	int gap_q;
	logic seen_q;
	// cycles since the last update; the first update has no reference phase
	always @(posedge ref_clk) begin
		if (!rst_n || target_update_q) begin
			gap_q <= 1;
		end else begin
			gap_q <= gap_q + 1;
		end
		seen_q <= rst_n && (seen_q || target_update_q);
	end
	// bus answer timing
	req_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	// host protocol enables: exactly one, changed only by a protocol write
	proto_onehot_a: assert property ($past(rst_n) |-> $onehot(protocol_enable_q))
		else $error("protocol enables not one-hot");
	proto_cause_a: assert property ($changed(protocol_enable_q) && $past(rst_n, 2) |->
		$past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[7:2] == 6'h08, 1)
		|| $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[7:2] == 6'h08, 2))
		else $error("protocol changed without write");
	proto_reset_a: assert property ($rose(rst_n) |=> protocol_enable_q == 4'h1)
		else $error("protocol enable wrong after reset");
	// target moves only on an update tick
	tgt_change_a: assert property ($changed(target_freq_q) && $past(rst_n, 2) |-> target_update_q)
		else $error("target changed off tick");
	upd_spacing_a: assert property (target_update_q && seen_q |-> (gap_q % UPDATE_DIV) == 0)
		else $error("update off the tick grid");
endmodule // freq_ref_select_asserts

bind freq_ref_select freq_ref_select_asserts #(.UPDATE_DIV(UPDATE_DIV)) i_freq_ref_select_asserts (
	.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .target_freq_q(target_freq_q),
	.protocol_enable_q(protocol_enable_q), .target_update_q(target_update_q));

/* verif/ref_inputs.sv */
// partner model: reference levels, speed terminals and up/down keys
`timescale 1ns/1ps
module ref_inputs (
	// clock
	input wire ref_clk,
	// analog, pulse and loop levels
	output logic [15:0] analog_voltage_input,
	output logic [15:0] analog_dual_input,
	output logic [15:0] analog_bipolar_input,
	output logic [15:0] pulse_input_terminal,
	output logic [15:0] plc_reference,
	output logic [15:0] pid_reference,
	// digital terminals
	output logic [3:0] speed_select,
	output logic freq_switch,
	output logic up_pulse,
	output logic down_pulse
);
	// all terminals quiet at power up
	initial begin
		{analog_voltage_input, analog_dual_input, analog_bipolar_input} = 48'h0;
		{pulse_input_terminal, plc_reference, pid_reference} = 48'h0;
		{speed_select, freq_switch, up_pulse, down_pulse} = 7'h00;
	end
	// levels change just after an edge and then stand
	task automatic levels(input logic [15:0] v, d, b, p, l, q);
		@(posedge ref_clk);
		analog_voltage_input <= v;
		analog_dual_input <= d;
		analog_bipolar_input <= b;
		pulse_input_terminal <= p;
		plc_reference <= l;
		pid_reference <= q;
	endtask
	// speed index and switchover terminal
	task automatic terms(input logic [3:0] s, input logic f);
		@(posedge ref_clk);
		speed_select <= s;
		freq_switch <= f;
	endtask
	// up (dir 1) or down for n cycles; every high cycle is one step
	task automatic keys(input logic dir, input int n);
		@(posedge ref_clk);
		up_pulse <= dir;
		down_pulse <= !dir;
		repeat (n) @(posedge ref_clk);
		up_pulse <= 1'b0;
		down_pulse <= 1'b0;
	endtask
endmodule // ref_inputs

/* verif/testbench.sv */
// self-checking bench for the frequency reference selector
`timescale 1ns/1ps
`include "freq_ref_defs.vh"
module testbench;
	localparam int UPD = 4;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h3;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] rd;
	wire [31:0] wb_dat_o;
	wire wb_ack_o;
	wire [15:0] av, ad, ab, pu, pl, pd, target_freq_q;
	wire [3:0] spd, protocol_enable_q;
	wire sw, up, dn, target_update_q;
	int failures = 0;
	int cmp_count = 0;

	always #20 ref_clk = ~ref_clk;

	// device under test and its terminal partner
	freq_ref_select #(.UPDATE_DIV(UPD)) i_freq_ref_select (.ref_clk(ref_clk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_voltage_input(av),
		.analog_dual_input(ad), .analog_bipolar_input(ab), .pulse_input_terminal(pu), .plc_reference(pl),
		.pid_reference(pd), .speed_select(spd), .freq_switch(sw), .up_pulse(up), .down_pulse(dn),
		.target_freq_q(target_freq_q), .protocol_enable_q(protocol_enable_q), .target_update_q(target_update_q));
	ref_inputs i_ref_inputs (.ref_clk(ref_clk), .analog_voltage_input(av), .analog_dual_input(ad),
		.analog_bipolar_input(ab), .pulse_input_terminal(pu), .plc_reference(pl), .pid_reference(pd),
		.speed_select(spd), .freq_switch(sw), .up_pulse(up), .down_pulse(dn));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; entered just after an edge, read data taken at the ack edge
	task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {16'h0000, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 64);
		rd = wb_dat_o;
		if (n >= 64) failures++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0000);
		chk(rd, e);
	endtask
	// settings land at the next tick, inputs within one more interval
	task automatic tchk(input logic [15:0] e);
		repeat (2 * UPD + 3) @(posedge ref_clk);
		chk({16'h0000, target_freq_q}, {16'h0000, e});
	endtask

	task automatic s_reset();
		rdchk(`OFS_AUX_SRC, 32'h0);
		rdchk(`OFS_AUX_REF, 32'h0);
		rdchk(`OFS_AUX_PCT, 32'h0);
		rdchk(`OFS_MODE, 32'h0);
		rdchk(`OFS_MAXF, 32'h1388);
		rdchk(`OFS_STATUS, 32'h3);
		chk({28'h0, protocol_enable_q}, 32'h1);
		tchk(16'h1388);
	endtask
	// protocol one-hot, unmapped place, out-of-range selector code
	task automatic s_bus();
		for (int p = 0; p < 4; p++) begin
			wr(`OFS_PROTO, 16'(p));
			chk({28'h0, protocol_enable_q}, 32'(1 << p));
		end
		wr(8'h38, 16'h1234);
		rdchk(8'h38, 32'h0);
		wr(`OFS_MAIN_SRC, 16'h000a);
		rdchk(`OFS_MAIN_SRC, 32'h0);
	endtask
	// preset table entries are percent of a max of 80.00 Hz
	task automatic s_mref();
		wr(`OFS_MAXF, 16'h1f40);
		wr(`OFS_MAIN_SRC, 16'h0006);
		for (int i = 0; i < 16; i++) wr(8'(`OFS_MREF_BASE + 4 * i), 16'((i + 1) * 500));
		for (int i = 0; i < 16; i++) begin
			i_ref_inputs.terms(4'(i), 1'b0);
			tchk(16'((i + 1) * 400));
		end
	endtask
	// channel codes two to nine on main (mode 0) and on aux (switched to Y)
	task automatic s_chan();
		logic [15:0] e [2:9] = '{16'h044c, 16'h04b0, 16'hfc18, 16'h0578, 16'h01f4, 16'h05dc, 16'h0640, 16'h06a4};
		wr(`OFS_MAXF, 16'h2710);
		wr(`OFS_AUX_PCT, 16'h0064);
		wr(`OFS_COMM, 16'h06a4);
		i_ref_inputs.levels(16'h044c, 16'h04b0, 16'hfc18, 16'h0578, 16'h05dc, 16'h0640);
		i_ref_inputs.terms(4'h0, 1'b1);
		wr(`OFS_MAIN_SRC, 16'h0001);
		for (int c = 2; c < 10; c++) begin
			wr(`OFS_MODE, 16'h0000);
			wr(`OFS_AUX_SRC, 16'h0000);
			wr(`OFS_MAIN_SRC, 16'(c));
			tchk(e[c]);
			wr(`OFS_MAIN_SRC, 16'h0001);
			wr(`OFS_AUX_SRC, 16'(c));
			wr(`OFS_MODE, 16'h0002);
			tchk(e[c]);
		end
	endtask
	// X 30.00, Y -40.00: all units and tens digits, then the offset
	task automatic s_comb();
		logic [15:0] m [11] = '{16'h0000, 16'h0001, 16'h000b, 16'h0015, 16'h001f, 16'h000c, 16'h000c,
			16'h000d, 16'h000d, 16'h000e, 16'h000e};
		logic [15:0] e [11] = '{16'h0bb8, 16'hfc18, 16'h1b58, 16'hf060, 16'h0bb8, 16'h0bb8, 16'hf060,
			16'h0bb8, 16'h1b58, 16'hf060, 16'h1b58};
		logic [10:0] s = 11'h540;
		wr(`OFS_MAIN_SRC, 16'h0002);
		wr(`OFS_AUX_SRC, 16'h0003);
		i_ref_inputs.levels(16'h0bb8, 16'hf060, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		for (int k = 0; k < 11; k++) begin
			i_ref_inputs.terms(4'h0, s[k]);
			wr(`OFS_MODE, m[k]);
			tchk(e[k]);
		end
		wr(`OFS_OFFSET, 16'h01f4);
		wr(`OFS_MODE, 16'h0001);
		tchk(16'hfe0c);
		rdchk(`OFS_TARGET, 32'h0000fe0c);
		rdchk(`OFS_MAIN_VAL, 32'h00000bb8);
		rdchk(`OFS_AUX_VAL, 32'h0000f060);
		wr(`OFS_MODE, 16'h0000);
		tchk(16'h0bb8);
		wr(`OFS_OFFSET, 16'h0000);
	endtask
	// aux range: 150 percent of max, then relative to a moving main
	task automatic s_range();
		wr(`OFS_MODE, 16'h0001);
		wr(`OFS_AUX_PCT, 16'h0096);
		tchk(16'hf448);
		wr(`OFS_AUX_PCT, 16'h0064);
		wr(`OFS_AUX_REF, 16'h0001);
		tchk(16'h0708);
		i_ref_inputs.levels(16'h1388, 16'hf060, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		tchk(16'h0bb8);
		wr(`OFS_AUX_PCT, 16'h0000);
		tchk(16'h1388);
	endtask
	// digital aux in combination: preset ignored, keys trim directly
	task automatic s_digital();
		wr(`OFS_AUX_REF, 16'h0000);
		wr(`OFS_AUX_PCT, 16'h0064);
		wr(`OFS_AUX_SRC, 16'h0000);
		tchk(16'h1388);
		i_ref_inputs.keys(1'b1, 5);
		tchk(16'h138d);
		i_ref_inputs.keys(1'b0, 2);
		tchk(16'h138b);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// watchdog well beyond the thousand or so cycles the sequence needs
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		s_reset();
		s_bus();
		s_mref();
		s_chan();
		s_comb();
		s_range();
		s_digital();
		close_out();
	end
endmodule // testbench
